// File: hw/fgs_pkg.sv
// Overview of operation
// R01: Method A offers one group, index 0, holding every frequency number 0 through 23.
// R02: Method B offers two groups of twelve, group 0 the even numbers and group 1 the odd numbers.
// R03: Method C offers three groups of eight, group g holding the numbers whose remainder modulo 3 is g.
// R04: Method D offers four groups of six, group g holding the numbers whose remainder modulo 4 is g.
// R05: Method E offers six groups of four, group g holding the numbers whose remainder modulo 6 is g.
// R06: Method F offers eight groups of three, group g holding g, g+8 and g+16.
// R07: Method G offers twelve groups of two, group g holding g and g+12.
// R08: Method H treats each index 0 to 23 as one fixed frequency equal to the index.
// R09: After factory-default initialization the selection is method F, group 0, giving three frequencies.
// R10: The operator should start communication tests with the fixed-frequency method H.
// R11: Under a grouping method a clear frequency is searched among the selected group's members.
// R12: With method A the search considers all 24 frequency numbers.
// R13: A group index at or above the method's group count is flagged invalid and yields no frequency set.
package fgs_pkg;

  localparam int unsigned FGS_NUM_FREQ = 24;
  localparam int unsigned FGS_FREQ_W   = 5;
  localparam logic [4:0]  FGS_LAST_FREQ = 5'h17;

  typedef enum logic [2:0] {
    FGS_METH_A = 3'h0,
    FGS_METH_B = 3'h1,
    FGS_METH_C = 3'h2,
    FGS_METH_D = 3'h3,
    FGS_METH_E = 3'h4,
    FGS_METH_F = 3'h5,
    FGS_METH_G = 3'h6,
    FGS_METH_H = 3'h7
  } fgs_method_t;

  typedef struct packed {
    fgs_method_t method;
    logic [4:0]  group;
  } fgs_sel_t;

  localparam fgs_method_t FGS_RST_METHOD = FGS_METH_F;
  localparam logic [4:0]  FGS_RST_GROUP  = 5'h00;
  localparam logic [23:0] FGS_RST_MASK   = 24'h010101;

  typedef enum logic [1:0] {
    FGS_ST_IDLE = 2'b00,
    FGS_ST_SCAN = 2'b01,
    FGS_ST_DONE = 2'b10
  } fgs_state_t;

  function automatic logic [4:0] fgs_group_count(input fgs_method_t m);
    case (m)
      FGS_METH_A: fgs_group_count = 5'h01;
      FGS_METH_B: fgs_group_count = 5'h02;
      FGS_METH_C: fgs_group_count = 5'h03;
      FGS_METH_D: fgs_group_count = 5'h04;
      FGS_METH_E: fgs_group_count = 5'h06;
      FGS_METH_F: fgs_group_count = 5'h08;
      FGS_METH_G: fgs_group_count = 5'h0c;
      default:    fgs_group_count = 5'h18;
    endcase
  endfunction

  // frequency f is a member when f modulo group count equals the group
  function automatic logic fgs_in_group(input fgs_method_t m, input logic [4:0] g, input int unsigned f);
    int unsigned cnt;
    cnt = 32'(fgs_group_count(m));
    fgs_in_group = (5'(f % cnt) == g);
  endfunction

endpackage

// File: hw/fgs_selector.sv
`timescale 1ns/10ps
module fgs_selector (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire fgs_pkg::fgs_sel_t    sel_in,
  input  wire logic                 sel_load,
  input  wire logic                 def_init,
  input  wire logic [23:0]          clear_mask,
  input  wire logic                 search_start,
  output fgs_pkg::fgs_sel_t         sel_r,
  output logic [23:0]               member_mask_r,
  output logic                      group_invalid_r,
  output logic                      fixed_mode_r,
  output logic                      search_busy_r,
  output logic                      search_done_r,
  output logic                      search_found_r,
  output logic [4:0]                found_freq_r
);
  import fgs_pkg::*;

  fgs_sel_t    sel_nxt;
  logic [23:0] mask_raw;
  logic [23:0] member_mask_nxt;
  logic        group_invalid_nxt;
  logic        fixed_mode_nxt;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // selection: factory default wins over a load
  always_comb begin
    sel_nxt = sel_r;
    if (def_init) begin
      sel_nxt.method = FGS_RST_METHOD; // see R09
      sel_nxt.group  = FGS_RST_GROUP;
    end else if (sel_load) begin
      sel_nxt = sel_in;
    end
  end

  genvar fi;
  generate
    for (fi = 0; fi < FGS_NUM_FREQ; fi++) begin : g_member
      // see R01 R02 R03 R04 R05 R06 R07 R08 R12
      assign mask_raw[fi] = fgs_in_group(sel_nxt.method, sel_nxt.group, fi);
    end
  endgenerate

  always_comb begin
    group_invalid_nxt = (sel_nxt.group >= fgs_group_count(sel_nxt.method)); // see R13
    member_mask_nxt   = group_invalid_nxt ? 24'h000000 : mask_raw; // see R13
    fixed_mode_nxt    = (sel_nxt.method == FGS_METH_H); // see R08
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_r.method    <= FGS_RST_METHOD; // see R09
      sel_r.group     <= FGS_RST_GROUP;
      member_mask_r   <= FGS_RST_MASK;
      group_invalid_r <= 1'b0;
      fixed_mode_r    <= 1'b0;
    end else begin
      sel_r           <= sel_nxt;
      member_mask_r   <= member_mask_nxt;
      group_invalid_r <= group_invalid_nxt;
      fixed_mode_r    <= fixed_mode_nxt;
    end
  end

  // one check per method A to G, three for method H
  all_freq_a: assert property (sel_r.method == FGS_METH_A && !group_invalid_r
      |-> member_mask_r == 24'hffffff) // see R01
    else $error("method A group does not hold all frequencies");
  even_odd_a: assert property (sel_r.method == FGS_METH_B && !group_invalid_r
      |-> member_mask_r == (sel_r.group[0] ? 24'haaaaaa : 24'h555555)) // see R02
    else $error("method B group is not even or odd set");
  mod_three_a: assert property (sel_r.method == FGS_METH_C && !group_invalid_r
      |-> member_mask_r == (24'h249249 << sel_r.group)) // see R03
    else $error("method C group wrong");
  mod_four_a: assert property (sel_r.method == FGS_METH_D && !group_invalid_r
      |-> member_mask_r == (24'h111111 << sel_r.group)) // see R04
    else $error("method D group wrong");
  mod_six_a: assert property (sel_r.method == FGS_METH_E && !group_invalid_r
      |-> member_mask_r == (24'h041041 << sel_r.group)) // see R05
    else $error("method E group wrong");
  eight_grp_a: assert property (sel_r.method == FGS_METH_F && !group_invalid_r
      |-> member_mask_r == (24'h010101 << sel_r.group)) // see R06
    else $error("method F group wrong");
  twelve_grp_a: assert property (sel_r.method == FGS_METH_G && !group_invalid_r
      |-> member_mask_r == (24'h001001 << sel_r.group)) // see R07
    else $error("method G group wrong");
  fixed_freq_a: assert property (sel_r.method == FGS_METH_H && !group_invalid_r
      |-> member_mask_r == (24'h000001 << sel_r.group) && fixed_mode_r) // see R08
    else $error("method H not a single fixed frequency");
  h_single_a: assert property (fixed_mode_r && !group_invalid_r
      |-> $onehot(member_mask_r)) // see R08
    else $error("fixed mode set does not hold one frequency");
  fixed_only_h_a: assert property (fixed_mode_r
      |-> sel_r.method == FGS_METH_H) // see R08
    else $error("fixed mode flag set outside method H");

  // default selection and invalid groups
  default_sel_a: assert property (def_init |=> sel_r.method == FGS_METH_F && sel_r.group == 5'h00
      && $countones(member_mask_r) == 3) // see R09
    else $error("factory default selection wrong");
  invalid_grp_a: assert property (sel_r.group >= fgs_group_count(sel_r.method)
      |-> group_invalid_r && member_mask_r == 24'h000000) // see R13
    else $error("invalid group not flagged");

  // clear-frequency search over the live member mask
  fgs_state_t state_r;
  fgs_state_t state_nxt;
  logic [4:0] idx_r;
  logic [4:0] idx_nxt;
  logic       search_found_nxt;
  logic [4:0] found_freq_nxt;

  always_comb begin
    state_nxt        = state_r;
    idx_nxt          = idx_r;
    search_found_nxt = search_found_r;
    found_freq_nxt   = found_freq_r;
    case (state_r)
      FGS_ST_IDLE: begin
        if (search_start) begin
          idx_nxt          = 5'h00;
          search_found_nxt = 1'b0;
          found_freq_nxt   = 5'h00;
          state_nxt        = group_invalid_r ? FGS_ST_DONE : FGS_ST_SCAN; // see R13
        end
      end
      // lowest-numbered clear member wins
      FGS_ST_SCAN: begin
        if (member_mask_r[idx_r] && clear_mask[idx_r]) begin // see R11
          search_found_nxt = 1'b1;
          found_freq_nxt   = idx_r;
          state_nxt        = FGS_ST_DONE;
        end else if (idx_r == FGS_LAST_FREQ) begin // see R12
          state_nxt = FGS_ST_DONE;
        end else begin
          idx_nxt = 5'(idx_r + 5'h01);
        end
      end
      FGS_ST_DONE: state_nxt = FGS_ST_IDLE;
      default:     state_nxt = FGS_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r        <= FGS_ST_IDLE;
      idx_r          <= 5'h00;
      search_busy_r  <= 1'b0;
      search_done_r  <= 1'b0;
      search_found_r <= 1'b0;
      found_freq_r   <= 5'h00;
    end else begin
      state_r        <= state_nxt;
      idx_r          <= idx_nxt;
      search_busy_r  <= (state_nxt == FGS_ST_SCAN);
      search_done_r  <= (state_nxt == FGS_ST_DONE);
      search_found_r <= search_found_nxt;
      found_freq_r   <= found_freq_nxt;
    end
  end

  // search start and refusal
  busy_start_a: assert property (state_r == FGS_ST_IDLE && search_start && !group_invalid_r
      |=> search_busy_r) // see R11
    else $error("valid start did not begin a scan");
  invalid_nofind_a: assert property (state_r == FGS_ST_IDLE && search_start && group_invalid_r
      |=> search_done_r && !search_found_r) // see R13
    else $error("invalid group search did not end at once");
  start_clears_a: assert property (state_r == FGS_ST_IDLE && search_start
      |=> !search_found_r && found_freq_r == 5'h00) // see R11
    else $error("start did not clear the last result");
  idle_hold_a: assert property (state_r == FGS_ST_IDLE && !search_start
      |=> !search_busy_r && !search_done_r) // see R11
    else $error("search ran without a start");
  scan_bound_a: assert property (state_r == FGS_ST_IDLE && search_start
      |-> ##[1:25] search_done_r) // see R12
    else $error("search did not finish within 24 steps");

  // scan stepping
  hit_stops_a: assert property (search_busy_r && member_mask_r[idx_r] && clear_mask[idx_r]
      |=> search_done_r && search_found_r && found_freq_r == $past(idx_r)) // see R11
    else $error("clear member did not end the scan");
  miss_step_a: assert property (search_busy_r && idx_r != FGS_LAST_FREQ
      && !(member_mask_r[idx_r] && clear_mask[idx_r])
      |=> search_busy_r && idx_r == $past(idx_r) + 5'h01) // see R11
    else $error("scan did not step to the next frequency");
  last_index_a: assert property (search_busy_r && idx_r == FGS_LAST_FREQ
      |=> search_done_r) // see R12
    else $error("scan went past the last frequency");
  scan_exit_a: assert property (search_busy_r
      |=> search_busy_r || search_done_r) // see R11
    else $error("scan left without a done pulse");

  // results
  busy_done_a: assert property (search_busy_r
      |-> !search_done_r) // see R11
    else $error("busy and done high together");
  done_pulse_a: assert property (search_done_r
      |=> !search_done_r) // see R11
    else $error("done held longer than one cycle");
  found_member_a: assert property (search_done_r && search_found_r
      |-> found_freq_r == $past(idx_r) && $past(member_mask_r[idx_r])) // see R11
    else $error("found frequency not in group");
  nofind_freq_a: assert property (search_done_r && !search_found_r
      |-> found_freq_r == 5'h00) // see R11
    else $error("frequency reported without a find");
  freq_range_a: assert property (search_found_r
      |-> found_freq_r <= FGS_LAST_FREQ) // see R12
    else $error("found frequency out of range");

  // main scenarios
  found_c:   cover property (search_done_r && search_found_r);
  nofound_c: cover property (search_done_r && !search_found_r);
  all_a_c:   cover property (sel_r.method == FGS_METH_A && search_done_r && found_freq_r == FGS_LAST_FREQ);
  invalid_c: cover property (group_invalid_r && search_done_r);
  fixed_c:   cover property (fixed_mode_r && search_done_r && search_found_r);

endmodule // fgs_selector

// File: dv/fgs_selector_tb.sv
`timescale 1ns/10ps
module frequency_group_selector_tb_top;
  import fgs_pkg::*;
  logic              clock        = 1'b0;
  logic              rst_n        = 1'b0;
  fgs_sel_t          sel_in       = '0;
  logic              sel_load     = 1'b0;
  logic              def_init     = 1'b0;
  logic [23:0]       clear_mask   = 24'h000000;
  logic              search_start = 1'b0;
  fgs_sel_t          sel_r;
  logic [23:0]       member_mask_r;
  logic              group_invalid_r, fixed_mode_r, search_busy_r, search_done_r, search_found_r;
  logic [4:0]        found_freq_r;
  int                miscompares  = 0;
  int                compares     = 0;
  int                cnt_tbl [8]  = '{1, 2, 3, 4, 6, 8, 12, 24};

  always #2.5 clock = ~clock;

  fgs_selector dut (.clock(clock), .rst_n(rst_n), .sel_in(sel_in), .sel_load(sel_load), .def_init(def_init),
    .clear_mask(clear_mask), .search_start(search_start), .sel_r(sel_r), .member_mask_r(member_mask_r),
    .group_invalid_r(group_invalid_r), .fixed_mode_r(fixed_mode_r), .search_busy_r(search_busy_r),
    .search_done_r(search_done_r), .search_found_r(search_found_r), .found_freq_r(found_freq_r));

  task automatic chk_num(input string what, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_flag(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic load(input logic [2:0] m, input logic [4:0] g, input logic dflt);
    @(negedge clock);
    sel_in   = '{method: fgs_method_t'(m), group: g};
    sel_load = 1'b1;
    def_init = dflt;
    @(negedge clock);
    sel_load = 1'b0;
    def_init = 1'b0;
  endtask

  // members are the numbers whose remainder by the group count equals the group
  function automatic logic [23:0] exp_mask(input int m, input int g);
    logic [23:0] r;
    r = 24'h000000;
    for (int f = 0; f < 24; f++) r[f] = ((f % cnt_tbl[m]) == g);
    return r;
  endfunction

  // counts sampling cycles from the start edge until done shows
  task automatic run_search(input logic [23:0] clr, output int cyc);
    @(negedge clock);
    clear_mask   = clr;
    search_start = 1'b1;
    @(negedge clock);
    search_start = 1'b0;
    cyc = 1;
    while (search_done_r !== 1'b1 && cyc < 40) begin
      @(negedge clock);
      cyc++;
    end
  endtask

  task automatic t_reset;
    chk_num("sel", {16'h0000, FGS_METH_F, 5'h00}, {16'h0000, sel_r});
    chk_num("mask", 24'h010101, member_mask_r);
    chk_flag("busy", 1'b0, search_busy_r);
    $display("t_reset done");
  endtask

  task automatic t_masks;
    for (int m = 0; m < 8; m++) begin
      for (int g = 0; g <= cnt_tbl[m] && g < 32; g++) begin
        load(3'(m), 5'(g), 1'b0);
        chk_num("mask", exp_mask(m, g), member_mask_r);
        chk_flag("invalid", g >= cnt_tbl[m], group_invalid_r);
        chk_flag("fixed", m == 7, fixed_mode_r);
      end
    end
    load(3'h2, 5'h01, 1'b0);
    chk_num("mask", 24'h492492, member_mask_r);
    load(3'h4, 5'h04, 1'b0);
    chk_num("mask", 24'h410410, member_mask_r);
    load(3'h5, 5'h06, 1'b0);
    chk_num("mask", 24'h404040, member_mask_r);
    load(3'h6, 5'h09, 1'b0);
    chk_num("mask", 24'h200200, member_mask_r);
    $display("t_masks done");
  endtask

  task automatic t_default;
    load(3'h2, 5'h01, 1'b1);
    chk_num("sel", {16'h0000, FGS_METH_F, 5'h00}, {16'h0000, sel_r});
    chk_num("mask", 24'h010101, member_mask_r);
    $display("t_default done");
  endtask

  task automatic t_search;
    int cyc;
    load(3'h7, 5'h09, 1'b0);
    run_search(24'h000200, cyc);
    chk_num("cycles", 24'd11, 24'(cyc));
    chk_flag("found", 1'b1, search_found_r);
    chk_num("freq", 24'd9, {19'h0, found_freq_r});
    load(3'h5, 5'h03, 1'b0);
    run_search(24'h080801, cyc);
    chk_num("cycles", 24'd13, 24'(cyc));
    chk_flag("found", 1'b1, search_found_r);
    chk_num("freq", 24'd11, {19'h0, found_freq_r});
    load(3'h0, 5'h00, 1'b0);
    run_search(24'h800000, cyc);
    chk_num("cycles", 24'd25, 24'(cyc));
    chk_num("freq", 24'd23, {19'h0, found_freq_r});
    run_search(24'h000000, cyc);
    chk_num("cycles", 24'd25, 24'(cyc));
    chk_flag("found", 1'b0, search_found_r);
    load(3'h1, 5'h02, 1'b0);
    run_search(24'hffffff, cyc);
    chk_num("cycles", 24'd1, 24'(cyc));
    chk_flag("found", 1'b0, search_found_r);
    $display("t_search done");
  endtask

  // busy and done shape, with a start during the scan that must be ignored
  task automatic t_flags;
    load(3'h3, 5'h02, 1'b0);
    @(negedge clock);
    clear_mask   = 24'h000040;
    search_start = 1'b1;
    @(negedge clock);
    search_start = 1'b0;
    chk_flag("busy", 1'b1, search_busy_r);
    chk_flag("done", 1'b0, search_done_r);
    repeat (2) @(negedge clock);
    search_start = 1'b1;
    @(negedge clock);
    search_start = 1'b0;
    repeat (3) @(negedge clock);
    chk_flag("done", 1'b0, search_done_r);
    @(negedge clock);
    chk_flag("done", 1'b1, search_done_r);
    chk_flag("busy", 1'b0, search_busy_r);
    chk_num("freq", 24'd6, {19'h0, found_freq_r});
    @(negedge clock);
    chk_flag("done", 1'b0, search_done_r);
    $display("t_flags done");
  endtask

  task automatic t_midreset;
    load(3'h7, 5'h1e, 1'b0);
    chk_flag("invalid", 1'b1, group_invalid_r);
    @(negedge clock);
    rst_n = 1'b0;
    @(negedge clock);
    chk_num("sel", {16'h0000, FGS_METH_F, 5'h00}, {16'h0000, sel_r});
    chk_num("mask", 24'h010101, member_mask_r);
    chk_flag("invalid", 1'b0, group_invalid_r);
    chk_flag("fixed", 1'b0, fixed_mode_r);
    rst_n = 1'b1;
    $display("t_midreset done");
  endtask

  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #20000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    t_reset();
    t_masks();
    t_default();
    t_search();
    t_flags();
    t_midreset();
    tally_and_finish();
  end
endmodule // frequency_group_selector_tb_top
